//--- dmd_core.sv
// decode and clock-count unit for the general data-transfer group
//
// Added by the designer: register access over APB and the address map.
`timescale 1ns/1ps
// Behaviour
// - two listed counts: lower for register operand, higher for memory.
// - components: displacement one, immediate one, each other byte one.
// - misaligned 16-bit or even 32-bit access adds 2, or 4 both ways.
// - odd-address 32-bit access adds 4, or 8 when read and written.
// - each wait state adds one clock per data access.
// - 1000100w store register to register/memory, 2 clocks always.
// - 1000101w load register, 2 from register, 4 from memory.
// - 1011wreg immediate to register, 2 clocks.
// - 1010000w load accumulator from full displacement, 4 clocks.
// - 1010001w store accumulator to full displacement, 2 clocks.
// - 10001110 segment load, 2/5 real, 22/23 protected.
// - 10001100 segment copy to register/memory, 2 clocks always.
// - 000ss110 push legacy segment, 2 real, 4 protected.
// - 0f then 10sss000 pushes any of six segment registers.
// - 011010s0 push immediate, 2 real, 4 protected.
// - two general register address components add one clock.
module dmd_core
  import dmd_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        bus_hold,
  output logic             exec_start,
  output logic      [7:0]  exec_clocks,
  output logic      [3:0]  exec_class,
  output logic             exec_busy,
  output logic             exec_done
);
  // software-visible state
  logic [31:0]   ctrl_reg;
  logic [31:0]   insn_reg;
  logic [31:0]   access_reg;
  logic          unknown_reg;
  logic          done_flag_reg;
  logic [31:0]   result_reg;
  logic [31:0]   prdata_reg;
  logic          pready_reg;
  logic          pslverr_reg;
  // sequencing state
  dmd_state_type state_reg;
  dmd_state_type state_next;
  logic [7:0]    cnt_reg;
  logic          start_reg;
  logic          done_reg;
  logic [7:0]    clocks_reg;
  logic [3:0]    class_reg;
  logic          busy_reg;

  dmd_ea_if ea ();
  dmd_ea_decode u_ea (.ea(ea));

  // bus decode
  wire setup    = psel & ~penable;
  wire access   = psel & penable & pready_reg;
  wire wr_acc   = access & pwrite;
  wire hit_ctrl = paddr == ADDR_CTRL;
  wire hit_insn = paddr == ADDR_INSN;
  wire hit_acc  = paddr == ADDR_ACCESS;
  wire hit_stat = paddr == ADDR_STATUS;
  wire hit_res  = paddr == ADDR_RESULT;
  wire mapped   = hit_ctrl | hit_insn | hit_acc | hit_stat | hit_res;
  wire is_idle  = state_reg == ST_IDLE;
  // a new instruction is only taken while the sequencer is idle
  wire insn_go  = wr_acc & hit_insn & is_idle;

  // configuration fields
  wire       prot    = ctrl_reg[CTRL_PROT_BIT];
  wire       op32    = ctrl_reg[CTRL_OP32_BIT];
  wire [7:0] op0     = insn_reg[7:0];
  wire [7:0] op1     = insn_reg[15:8];
  wire [7:0] rd_wait = {4'h0, access_reg[ACC_RDW_LSB +: 4]};
  wire [7:0] wr_wait = {4'h0, access_reg[ACC_WRW_LSB +: 4]};
  wire       odd     = access_reg[ACC_ODD_BIT];
  wire [3:0] pfx_cnt = {1'b0, access_reg[ACC_PFX_LSB +: 3]};

  // full width follows the operand-size attribute
  wire [1:0] full_w = op32 ? W_DWORD : W_WORD;
  wire [7:0] push_t = prot ? T_PUSH_PROT : T_PUSH_REAL;

  assign ea.modrm   = op1;
  assign ea.sib     = insn_reg[23:16];
  assign ea.addr32  = ctrl_reg[CTRL_ADDR32_BIT];

  // opcode table
  logic [3:0] d_class;
  logic       d_modrm;
  logic       d_imm;
  logic       d_fulldisp;
  logic       d_esc;
  logic       d_rd;
  logic       d_wr;
  logic [1:0] d_width;
  logic [2:0] d_seg;
  logic [2:0] d_reg;
  logic [7:0] d_base;
  always_comb
  begin
    d_class    = CLS_NONE;
    d_modrm    = 1'b0;
    d_imm      = 1'b0;
    d_fulldisp = 1'b0;
    d_esc      = 1'b0;
    d_rd       = 1'b0;
    d_wr       = 1'b0;
    d_width    = op0[0] ? full_w : W_BYTE;
    d_seg      = 3'h0;
    d_reg      = op1[5:3];
    d_base     = 8'h00;
    casez (op0)
      8'b1000100?:
      begin
        d_class = CLS_STORE;
        d_modrm = 1'b1;
        d_wr    = ea.mem_op;
        d_base  = T_TWO;
      end
      8'b1000101?:
      begin
        d_class = CLS_LOAD;
        d_modrm = 1'b1;
        d_rd    = ea.mem_op;
        d_base  = ea.mem_op ? T_LOAD_MEM : T_TWO;
      end
      8'b1100011?:
      begin
        d_class = CLS_IMM_RM;
        d_modrm = 1'b1;
        d_imm   = 1'b1;
        d_wr    = ea.mem_op;
        d_base  = T_TWO;
      end
      8'b1011????:
      begin
        d_class = CLS_IMM_RG;
        d_imm   = 1'b1;
        d_width = op0[3] ? full_w : W_BYTE;
        d_reg   = op0[2:0];
        d_base  = T_TWO;
      end
      8'b1010000?:
      begin
        d_class    = CLS_ACC_LD;
        d_fulldisp = 1'b1;
        d_rd       = 1'b1;
        d_reg      = 3'h0;
        d_base     = T_ACC_LOAD;
      end
      8'b1010001?:
      begin
        d_class    = CLS_ACC_ST;
        d_fulldisp = 1'b1;
        d_wr       = 1'b1;
        d_reg      = 3'h0;
        d_base     = T_TWO;
      end
      8'b10001110:
      begin
        d_class = CLS_SEG_LD;
        d_modrm = 1'b1;
        d_rd    = ea.mem_op;
        d_width = W_WORD;
        d_seg   = op1[5:3];
        // protected mode reloads a descriptor as well
        if (prot)
          d_base = ea.mem_op ? T_SEGLD_PMEM : T_SEGLD_PREG;
        else
          d_base = ea.mem_op ? T_SEGLD_RMEM : T_TWO;
      end
      8'b10001100:
      begin
        d_class = CLS_SEG_ST;
        d_modrm = 1'b1;
        d_wr    = ea.mem_op;
        d_width = W_WORD;
        d_seg   = op1[5:3];
        d_base  = T_TWO;
      end
      8'b000??110:
      begin
        d_class = CLS_PSH_S2;
        d_wr    = 1'b1;
        d_width = full_w;
        d_seg   = {1'b0, op0[4:3]};
        d_base  = push_t;
      end
      8'b00001111:
      begin
        // only the segment push is handled behind the escape
        if ((op1[7:6] == 2'b10) && (op1[2:0] == 3'b000))
        begin
          d_class = CLS_PSH_S3;
          d_esc   = 1'b1;
          d_wr    = 1'b1;
          d_width = full_w;
          d_seg   = op1[5:3];
          d_base  = push_t;
        end
      end
      8'b011010?0:
      begin
        d_class = CLS_PSH_IM;
        d_imm   = 1'b1;
        d_wr    = 1'b1;
        d_width = full_w;
        d_base  = push_t;
      end
      8'b01010???:
      begin
        d_class = CLS_PSH_RG;
        d_wr    = 1'b1;
        d_width = full_w;
        d_reg   = op0[2:0];
        d_base  = push_t;
      end
      default:
      begin
        d_class = CLS_NONE;
      end
    endcase
  end

  // operand-location byte follows these opcodes; decoded apart from the
  // table so the address analyser never loops back into its own input
  assign ea.present = (op0[7:2] == 6'b100010) | (op0[7:1] == 7'b1100011)
                    | (op0 == 8'h8c) | (op0 == 8'h8e);

  // accumulator forms always address memory
  wire       op_mem = ea.mem_op | d_fulldisp;
  // instruction size in components
  wire [3:0] comps  = pfx_cnt + (d_esc ? 4'h2 : 4'h1)
                    + {3'h0, d_modrm} + {3'h0, ea.has_sib}
                    + {3'h0, ea.has_disp | d_fulldisp}
                    + {3'h0, d_imm};

  // alignment penalty, only for word and dword data
  wire       both   = d_rd & d_wr;
  wire       one    = d_rd ^ d_wr;
  wire       mis_sh = ((d_width == W_WORD) & odd)
                    | ((d_width == W_DWORD) & ~odd);
  wire       mis_lg = (d_width == W_DWORD) & odd;
  wire [7:0] mis_t  = mis_lg ? (both ? MIS_LONG_BOTH : one ? MIS_LONG_ONE
                                                           : 8'h00)
                    : mis_sh ? (both ? MIS_SHORT_BOTH
                                     : one ? MIS_SHORT_ONE : 8'h00)
                    : 8'h00;
  // every data access carries its own wait states
  wire [7:0] wait_t = (d_rd ? rd_wait : 8'h00)
                    + (d_wr ? wr_wait : 8'h00);
  wire [7:0] ea_t   = ea.two_reg ? EA_TWO_REG_ADD : 8'h00;
  wire [7:0] total  = (d_class == CLS_NONE) ? 8'h00
                    : d_base + mis_t + wait_t + ea_t;

  wire [31:0] status_word = {24'h0, class_reg, 1'b0, unknown_reg,
                             done_flag_reg, ~is_idle};
  wire [31:0] rd_mux = hit_ctrl ? ctrl_reg
                     : hit_insn ? insn_reg
                     : hit_acc  ? access_reg
                     : hit_stat ? status_word
                     : hit_res  ? result_reg
                     : 32'h0000_0000;

  // apb answer: data registered in setup, ready in the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_reg  <= 32'h0000_0000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      prdata_reg  <= setup ? rd_mux : prdata_reg;
      pready_reg  <= setup;
      pslverr_reg <= setup & ~mapped;
    end
  end

  // writable registers; insn writes while busy are dropped
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_reg   <= CTRL_RST;
      insn_reg   <= INSN_RST;
      access_reg <= ACCESS_RST;
    end
    else
    begin
      if (wr_acc & hit_ctrl)
        ctrl_reg <= pwdata;
      if (insn_go)
        insn_reg <= pwdata;
      if (wr_acc & hit_acc)
        access_reg <= pwdata;
    end
  end

  // sequencer: decode, then run the count down
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
        state_next = insn_go ? ST_DECODE : ST_IDLE;
      ST_DECODE:
        state_next = (total == 8'h00) ? ST_DONE : ST_COUNT;
      // a bus hold freezes the count; it is outside the listed figure
      ST_COUNT:
        state_next = (!bus_hold && cnt_reg == 8'h01) ? ST_DONE
                                                     : ST_COUNT;
      ST_DONE:
        state_next = ST_IDLE;
      default:
        state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_reg <= ST_IDLE;
    else
      state_reg <= state_next;
  end

  // count starts from a fully decoded instruction
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_reg <= 8'h00;
    else if (state_reg == ST_DECODE)
      cnt_reg <= total;
    else if (state_reg == ST_COUNT && !bus_hold)
      cnt_reg <= cnt_reg - 8'h01;
  end

  // decode results captured for software and the sequencer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      result_reg  <= 32'h0000_0000;
      unknown_reg <= 1'b0;
      class_reg   <= CLS_NONE;
      clocks_reg  <= 8'h00;
    end
    else if (state_reg == ST_DECODE)
    begin
      result_reg  <= {10'h0, d_reg, d_seg, d_width, ea.two_reg,
                      op_mem, comps, total};
      unknown_reg <= d_class == CLS_NONE;
      class_reg   <= d_class;
      clocks_reg  <= total;
    end
  end

  // done flag: set by completion, cleared by a new instruction
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      done_flag_reg <= 1'b0;
    else if (state_reg == ST_DONE)
      done_flag_reg <= 1'b1;
    else if (insn_go)
      done_flag_reg <= 1'b0;
  end

  // one-cycle hand-off pulses
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      start_reg <= 1'b0;
      done_reg  <= 1'b0;
    end
    else
    begin
      start_reg <= (state_reg == ST_DECODE) & (total != 8'h00);
      done_reg  <= state_reg == ST_DONE;
    end
  end

  assign prdata      = prdata_reg;
  assign pready      = pready_reg;
  assign pslverr     = pslverr_reg;
  assign exec_start  = start_reg;
  assign exec_clocks = clocks_reg;
  assign exec_class  = class_reg;
  assign exec_busy   = busy_reg;
  assign exec_done   = done_reg;

  // busy from a flop: rises with the start pulse, falls with done
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      busy_reg <= 1'b0;
    else if (state_reg == ST_DONE)
      busy_reg <= 1'b0;
    else if (state_reg == ST_DECODE)
      busy_reg <= total != 8'h00;
  end
endmodule

//--- dmd_pkg.sv
// shared constants and types for the data-move decode and timing block
package dmd_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_INSN   = 8'h04;
  localparam logic [7:0] ADDR_ACCESS = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_RESULT = 8'h10;
  // reset values
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [31:0] INSN_RST   = 32'h0000_0000;
  localparam logic [31:0] ACCESS_RST = 32'h0000_0000;
  // field positions
  localparam int CTRL_PROT_BIT   = 0;
  localparam int CTRL_OP32_BIT   = 1;
  localparam int CTRL_ADDR32_BIT = 2;
  localparam int ACC_RDW_LSB     = 0;
  localparam int ACC_WRW_LSB     = 4;
  localparam int ACC_ODD_BIT     = 8;
  localparam int ACC_PFX_LSB     = 9;
  // base execution clocks
  localparam logic [7:0] T_TWO        = 8'h02;
  localparam logic [7:0] T_ACC_LOAD   = 8'h04;
  localparam logic [7:0] T_LOAD_MEM   = 8'h04;
  localparam logic [7:0] T_SEGLD_RMEM = 8'h05;
  localparam logic [7:0] T_SEGLD_PREG = 8'h16;
  localparam logic [7:0] T_SEGLD_PMEM = 8'h17;
  localparam logic [7:0] T_PUSH_REAL  = 8'h02;
  localparam logic [7:0] T_PUSH_PROT  = 8'h04;
  // added clocks
  localparam logic [7:0] MIS_SHORT_ONE  = 8'h02;
  localparam logic [7:0] MIS_SHORT_BOTH = 8'h04;
  localparam logic [7:0] MIS_LONG_ONE   = 8'h04;
  localparam logic [7:0] MIS_LONG_BOTH  = 8'h08;
  localparam logic [7:0] EA_TWO_REG_ADD = 8'h01;
  // instruction classes
  localparam logic [3:0] CLS_NONE   = 4'h0;
  localparam logic [3:0] CLS_STORE  = 4'h1;
  localparam logic [3:0] CLS_LOAD   = 4'h2;
  localparam logic [3:0] CLS_IMM_RM = 4'h3;
  localparam logic [3:0] CLS_IMM_RG = 4'h4;
  localparam logic [3:0] CLS_ACC_LD = 4'h5;
  localparam logic [3:0] CLS_ACC_ST = 4'h6;
  localparam logic [3:0] CLS_SEG_LD = 4'h7;
  localparam logic [3:0] CLS_SEG_ST = 4'h8;
  localparam logic [3:0] CLS_PSH_S2 = 4'h9;
  localparam logic [3:0] CLS_PSH_S3 = 4'ha;
  localparam logic [3:0] CLS_PSH_IM = 4'hb;
  localparam logic [3:0] CLS_PSH_RG = 4'hc;
  // operand width codes
  localparam logic [1:0] W_BYTE  = 2'h0;
  localparam logic [1:0] W_WORD  = 2'h1;
  localparam logic [1:0] W_DWORD = 2'h2;
  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_DECODE = 4'b0010,
    ST_COUNT  = 4'b0100,
    ST_DONE   = 4'b1000
  } dmd_state_type;
endpackage

//--- dmd_ea_if.sv
// interface between the opcode table and the address-form analyser
`timescale 1ns/1ps
interface dmd_ea_if;
  logic [7:0] modrm;
  logic [7:0] sib;
  logic       addr32;
  logic       present;
  logic       mem_op;
  logic       has_sib;
  logic       has_disp;
  logic       two_reg;
  modport core (output modrm, sib, addr32, present,
                input mem_op, has_sib, has_disp, two_reg);
  modport ana  (input modrm, sib, addr32, present,
                output mem_op, has_sib, has_disp, two_reg);
endinterface

//--- dmd_ea_decode.sv
// address-form analyser: operand location, sib, displacement, two-reg
`timescale 1ns/1ps
module dmd_ea_decode
  import dmd_pkg::*;
(
  dmd_ea_if.ana ea
);
  wire [1:0] md    = ea.modrm[7:6];
  wire [2:0] rm    = ea.modrm[2:0];
  wire [2:0] base  = ea.sib[2:0];
  wire [2:0] index = ea.sib[5:3];
  wire       mem   = ea.present & (md != 2'b11);
  wire       dsp8_32 = (md == 2'b01) | (md == 2'b10);
  // 32-bit addressing escapes to a sib byte through r/m 100
  wire       sib32 = mem & ea.addr32 & (rm == 3'b100);
  wire       nobase = (md == 2'b00) & (base == 3'b101);
  wire       disp16 = dsp8_32 | ((md == 2'b00) & (rm == 3'b110));
  wire       disp32 = dsp8_32 | ((md == 2'b00) & (rm == 3'b101))
                    | (sib32 & nobase);
  // base+index pairs; a scaled index with no base is a single register
  wire       two16 = ~rm[2];
  wire       two32 = sib32 & (index != 3'b100) & ~nobase;

  assign ea.mem_op   = mem;
  assign ea.has_sib  = sib32;
  assign ea.has_disp = mem & (ea.addr32 ? disp32 : disp16);
  assign ea.two_reg  = mem & (ea.addr32 ? two32 : two16);
endmodule

//--- dmd_monitor.sv
// assertion checker for the data-move decode and timing block
`timescale 1ns/1ps
module dmd_monitor
  import dmd_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        bus_hold,
  input wire logic        exec_start,
  input wire logic [7:0]  exec_clocks,
  input wire logic [3:0]  exec_class,
  input wire logic        exec_busy,
  input wire logic        exec_done
);
  logic [7:0] gap_reg;
  logic       run_reg;
  logic       hold_seen_reg;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // cycles since start; any hold spoils the exact figure, so note it
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      gap_reg       <= 8'h00;
      run_reg       <= 1'b0;
      hold_seen_reg <= 1'b0;
    end
    else if (exec_start)
    begin
      gap_reg       <= 8'h01;
      run_reg       <= 1'b1;
      hold_seen_reg <= bus_hold;
    end
    else if (exec_done)
      run_reg       <= 1'b0;
    else
    begin
      gap_reg       <= gap_reg + 8'h01;
      hold_seen_reg <= hold_seen_reg | bus_hold;
    end

  // bus answer timing
  property p_ready_setup;
    psel && !penable |=> pready;
  endproperty
  a_ready_setup: assert property (p_ready_setup) else $error("no pready");
  property p_ready_one;
    pready |=> !pready;
  endproperty
  a_ready_one: assert property (p_ready_one) else $error("pready too long");
  property p_err_map;
    psel && !penable && paddr > ADDR_RESULT |=> pslverr && prdata == 32'h0;
  endproperty
  a_err_map: assert property (p_err_map) else $error("unmapped not refused");
  property p_err_ready;
    pslverr |-> pready;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("stray pslverr");

  // sequencer hand-off
  property p_start_pulse;
    exec_start |=> !exec_start;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("long start");
  property p_start_ok;
    exec_start |-> exec_busy && exec_clocks >= T_TWO && exec_class != CLS_NONE;
  endproperty
  a_start_ok: assert property (p_start_ok) else $error("bad start figures");
  property p_done_release;
    exec_done |-> ##[0:1] !exec_busy;
  endproperty
  a_done_release: assert property (p_done_release) else $error("busy stuck");
  property p_hold_vals;
    exec_busy && !exec_start |-> $stable(exec_clocks) && $stable(exec_class);
  endproperty
  a_hold_vals: assert property (p_hold_vals) else $error("count moved");
  property p_done_time;
    exec_done && run_reg && !hold_seen_reg |-> gap_reg == exec_clocks + 8'h01;
  endproperty
  a_done_time: assert property (p_done_time)
    else $error("done at wrong cycle");
endmodule

bind dmd_core dmd_monitor u_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .bus_hold(bus_hold),
  .exec_start(exec_start), .exec_clocks(exec_clocks),
  .exec_class(exec_class), .exec_busy(exec_busy), .exec_done(exec_done));

//--- dmd_seq_model.sv
// sequencer stand-in: stalls the count with bus_hold and times each run
`timescale 1ns/1ps
module dmd_seq_model
(
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       exec_start,
  input wire logic       exec_done,
  input wire logic [3:0] hold_len,
  output logic           bus_hold,
  output logic     [7:0] last_gap
);
  logic [3:0] hold_reg;
  logic [7:0] gap_reg;

  // hold comes right after a start, as a bus master grabbing the bus
  assign bus_hold = hold_reg != 4'h0;

  // gap counts cycles from the start pulse up to the done pulse
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      hold_reg <= 4'h0;
      gap_reg  <= 8'h00;
      last_gap <= 8'h00;
    end
    else if (exec_start)
    begin
      hold_reg <= hold_len;
      gap_reg  <= 8'h01;
    end
    else
    begin
      hold_reg <= hold_reg - {3'h0, bus_hold};
      gap_reg  <= gap_reg + 8'h01;
      if (exec_done)
        last_gap <= gap_reg;
    end
endmodule

//--- tb_top.sv
// self-checking bench for the data-move decode and timing block
`timescale 1ns/1ps
module tb_top
  import dmd_pkg::*;
();
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  hold_len = 4'h0;
  logic [31:0] prdata, rd_q, res;
  logic [7:0]  exec_clocks, last_gap;
  logic [3:0]  exec_class;
  logic        pready, pslverr, bus_hold, err_q;
  logic        exec_start, exec_busy, exec_done;
  int          fails = 0;
  int          comparisons = 0;

  dmd_core dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .bus_hold(bus_hold),
    .exec_start(exec_start), .exec_clocks(exec_clocks),
    .exec_class(exec_class), .exec_busy(exec_busy), .exec_done(exec_done));
  dmd_seq_model seq (
    .pclk(pclk), .presetn(presetn), .exec_start(exec_start),
    .exec_done(exec_done), .hold_len(hold_len), .bus_hold(bus_hold),
    .last_gap(last_gap));

  always #5 pclk = ~pclk;

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one transfer; no latency assumed, only the bounded wait
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // look mid-cycle, where pready and prdata are settled for the edge
    do
    begin
      @(negedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (pready !== 1'b1) fails++;
    rd_q = prdata;
    err_q = pslverr;
    @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // poll status until idle with done set
  task automatic wait_done();
    int n;
    n = 0;
    rd_q = 32'h0;
    while (rd_q[1:0] !== 2'b10 && n < 100)
    begin
      apb(1'b0, ADDR_STATUS, 32'h0);
      n++;
    end
    if (rd_q[1:0] !== 2'b10) fails++;
  endtask

  // mode, access shape, instruction; then total, port and done timing
  task automatic run(input logic [31:0] c, input logic [31:0] ac,
                     input logic [31:0] ins, input logic [7:0] exp);
    apb(1'b1, ADDR_CTRL, c);
    apb(1'b1, ADDR_ACCESS, ac);
    apb(1'b1, ADDR_INSN, ins);
    wait_done();
    apb(1'b0, ADDR_RESULT, 32'h0);
    res = rd_q;
    check({24'h0, res[7:0]}, {24'h0, exp});
    check({24'h0, exec_clocks}, {24'h0, exp});
    check({24'h0, last_gap}, {24'h0, exp + 8'h01 + {4'h0, hold_len}});
  endtask

  task automatic complete_run();
    $display("counts: comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    logic [7:0] e;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b0, 8'(i * 4), 32'h0);
      check(rd_q, 32'h0);
    end
    apb(1'b0, 8'h14, 32'h0);
    check({31'h0, err_q}, 32'h1);
    apb(1'b1, ADDR_CTRL, 32'h7);
    apb(1'b0, ADDR_CTRL, 32'h0);
    check(rd_q, 32'h7);
    $display("test registers done");
    run(32'h0, 32'h0, 32'hc089, 8'h02);
    run(32'h1, 32'h0, 32'h0689, 8'h02);
    run(32'h0, 32'h0, 32'hc08b, 8'h02);
    run(32'h1, 32'h0, 32'h068b, 8'h04);
    run(32'h0, 32'h0, 32'h008b, 8'h05);
    check({31'h0, res[13]}, 32'h1);
    run(32'h4, 32'h0, 32'h85048b, 8'h04);
    run(32'h0, 32'h0, 32'h00b8, 8'h02);
    check({30'h0, res[15:14]}, 32'h1);
    run(32'h2, 32'h0, 32'h00b0, 8'h02);
    check({30'h0, res[15:14]}, 32'h0);
    run(32'h1, 32'h0, 32'h00a1, 8'h04);
    run(32'h1, 32'h0, 32'h00a3, 8'h02);
    run(32'h0, 32'h0, 32'hd88e, 8'h02);
    run(32'h0, 32'h0, 32'h1e8e, 8'h05);
    run(32'h1, 32'h0, 32'hd88e, 8'h16);
    run(32'h1, 32'h0, 32'h1e8e, 8'h17);
    run(32'h0, 32'h0, 32'hd88c, 8'h02);
    run(32'h1, 32'h0, 32'h1e8c, 8'h02);
    run(32'h0, 32'h100, 32'h068b, 8'h06);
    run(32'h2, 32'h0, 32'h068b, 8'h06);
    check({30'h0, res[15:14]}, 32'h2);
    run(32'h0, 32'h100, 32'h068a, 8'h04);
    run(32'h2, 32'h100, 32'h068b, 8'h08);
    run(32'h2, 32'h100, 32'h0689, 8'h06);
    run(32'h0, 32'h53, 32'h068b, 8'h07);
    run(32'h0, 32'h53, 32'h0689, 8'h07);
    run(32'h0, 32'h53, 32'hc08b, 8'h02);
    run(32'h0, 32'h402, 32'hc08b, 8'h02);
    check({28'h0, res[11:8]}, 32'h4);
    run(32'h0, 32'h0, 32'h068b, 8'h04);
    check({28'h0, res[11:8]}, 32'h3);
    // every segment and immediate push form in both modes; register push is not run
    for (int m = 0; m < 2; m++)
    begin
      e = (m == 1) ? 8'h04 : 8'h02;
      for (int s = 0; s < 4; s++)
        run(32'(m), 32'h0, 32'(s * 8 + 6), e);
      for (int s = 0; s < 6; s++)
      begin
        run(32'(m), 32'h0, 32'(s * 2048 + 32'h800f), e);
        check({29'h0, res[18:16]}, 32'(s));
      end
      run(32'(m), 32'h0, 32'h68, e);
      run(32'(m), 32'h0, 32'h6a, e);
    end
    // a bus hold stretches the run but not the listed count
    hold_len <= 4'h3;
    run(32'h0, 32'h0, 32'h068b, 8'h04);
    hold_len <= 4'h0;
    apb(1'b1, ADDR_INSN, 32'h90);
    wait_done();
    check({28'h0, rd_q[7:4]}, 32'h0);
    check({31'h0, rd_q[2]}, 32'h1);
    check({28'h0, exec_class}, {28'h0, CLS_NONE});
    $display("test instructions done");
    complete_run();
  end

  // hang guard; the sequence needs a small part of this span
  initial
  begin
    #200us;
    fails++;
    complete_run();
  end
endmodule
